/* rtl/sps_params.svh */
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define SPS_CLK_KHZ    100000
`define SPS_EVM_MS     3000
`define SPS_BIT_MS     100
`define SPS_DAY_MIN    12'h5a0
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SPS_CTRL_OFS   8'h00
`define SPS_DLY_OFS    8'h04
`define SPS_INT_OFS    8'h08
`define SPS_PRG_OFS    8'h0c
`define SPS_KEY_OFS    8'h10
`define SPS_STAT_OFS   8'h14
// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define SPS_C_START    0
`define SPS_C_STORM    1
`define SPS_C_TSW      2
`define SPS_C_SREN     3
`define SPS_C_ATSTOP   4
`define SPS_C_ATRES    5
`define SPS_C_HASST    6
`define SPS_C_ONINH    7
`define SPS_C_ONENA    8
`define SPS_C_RESTART  9
`define SPS_C_FREEZE   10
`define SPS_C_FLOW     11
`define SPS_C_PULSE    12
`define SPS_C_FWD      13
`define SPS_C_REINIT   14
`define SPS_C_ABORT    15
// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define SPS_CTRL_RST   16'h2000
`define SPS_DLY_RST    8'h02
`define SPS_PRE_RST    14'h0096
`define SPS_POST_RST   14'h0096
`define SPS_PURGE_MAX  14'h270f
`define SPS_NKEY       24
`define SPS_NSTOP      12
`endif

/* rtl/sps_pkg.sv */
package sps_pkg;
  // Routine state, Gray along idle-wait-run-stop
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_WAIT = 2'b01,
    SPS_RUN  = 2'b11,
    SPS_STOP = 2'b10
  } sps_state_t;
  // Real-time clock view
  typedef struct packed {
    logic        tick;
    logic [5:0]  sec;
    logic [10:0] mins;
  } sps_rtc_t;
  // Pump cycle phases
  typedef struct packed {
    logic pre;
    logic fwd;
    logic post;
  } sps_pump_t;
endpackage : sps_pkg

/* rtl/sps_sequencer.sv */
// Overview of operation
// R1 - Up to 24 key times, 12 stop, 12 resume
// R2 - Stop/resume ignored in burst routines
// R3 - Resume restarts the bottle-switch interval
// R4 - Optional sample at stop and resume
// R5 - Zero delay starts and samples immediately
// R6 - Time intervals align to minute; flow immediate
// R7 - Delay N starts N minutes later at :00
// R8 - Programmed start time overrides the delay
// R9 - Enable high enables, low inhibits
// R10 - Enable settings ignored in burst routines
// R11 - Optional sample on enable falling edge
// R12 - Optional sample on enable rising edge
// R13 - Optional full interval reload on enable
// R14 - Freeze countdown when inhibited, unless reload
// R15 - After inhibit, advance set if filled
// R16 - Time-switched advance is exactly one set
// R17 - Four event mark behaviours selectable
// R18 - Bottle number as 100 ms pulse train
// R19 - Pulse mark 3 s; level mark at least 3 s
// R20 - Level tracks whole cycle or forward only
// R21 - Pulse at pre-purge or forward start
// R22 - Pre-purge defaults 150, range 0 to 9999
// R23 - Outputs idle low outside their intervals
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_sequencer #(
  parameter int          NBOT    = 24,
  parameter int unsigned EVM_CYC = `SPS_EVM_MS * `SPS_CLK_KHZ,
  parameter int unsigned BIT_CYC = `SPS_BIT_MS * `SPS_CLK_KHZ
) (
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire sps_pkg::sps_rtc_t  rtc_i,
  input  wire sps_pkg::sps_pump_t pump_i,
  input  wire logic               flow_pulse_i,
  input  wire logic               enable_i,
  input  wire logic               sample_done_i,
  output logic                    sample_req_o,
  output logic                    event_mark_o,
  output logic                    bottle_pulse_o,
  output logic      [4:0]         bottle_num_o,
  output logic      [13:0]        pre_purge_o,
  output logic      [13:0]        post_purge_o
);
  import sps_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sps_state_t                st;
    logic [15:0]               ctrl;
    logic [7:0]                dly;
    logic [10:0]               stmin;
    logic [15:0]               sint;
    logic [15:0]               swint;
    logic [13:0]               pre;
    logic [13:0]               post;
    logic [`SPS_NKEY-1:0][10:0] kmin;
    logic [`SPS_NKEY-1:0]      kval;
    logic [10:0]               tgt;
    logic [15:0]               cnt;
    logic [15:0]               swc;
    logic [4:0]                bot;
    logic [7:0]                dep;
    logic                      en_q;
    logic                      pp_q;
    logic                      fw_q;
    logic [31:0]               evc;
    logic [31:0]               bitc;
    logic [5:0]                bpn;
    logic                      bph;
    logic                      evm;
    logic                      samp;
    logic [31:0]               rdata;
  } sps_seq_t;

  sps_seq_t s_q;
  sps_seq_t s_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Purge entries above the limit are clipped, not wrapped
  function automatic logic [13:0] clip(input logic [13:0] v);
    clip = (v > `SPS_PURGE_MAX) ? `SPS_PURGE_MAX : v; // R22
  endfunction : clip

  function automatic logic [4:0] nxt_bot(input logic [4:0] b);
    nxt_bot = (b >= 5'(NBOT)) ? 5'h01 : 5'(b + 5'h01);
  endfunction : nxt_bot

  function automatic logic hit(input logic [7:0] a);
    hit = (a == `SPS_CTRL_OFS) || (a == `SPS_DLY_OFS) ||
          (a == `SPS_INT_OFS) || (a == `SPS_PRG_OFS) ||
          (a == `SPS_KEY_OFS) || (a == `SPS_STAT_OFS);
  endfunction : hit

  logic        wr;
  logic        start;
  logic        storm;
  logic        inh;
  logic        en_rise;
  logic        en_fall;
  logic        bnd;
  logic        pace;
  logic        hold;
  logic        fire;
  logic        adv;
  logic        trig;
  logic        phase;
  logic        k_stop;
  logic        k_res;
  logic [11:0] msum;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.samp = 1'b0;
    s_d.en_q = enable_i;
    s_d.pp_q = pump_i.pre;
    s_d.fw_q = pump_i.fwd;
    wr    = psel_i & penable_i & pwrite_i;
    start = wr & (paddr_i == `SPS_CTRL_OFS) & pwdata_i[`SPS_C_START];
    storm = s_q.ctrl[`SPS_C_STORM];
    // High level enables, low or grounded inhibits
    inh     = ~enable_i; // R9
    en_rise = enable_i & ~s_q.en_q & ~storm; // R10
    en_fall = ~enable_i & s_q.en_q & ~storm; // R10
    bnd   = rtc_i.tick & (rtc_i.sec == 6'h00);
    pace  = s_q.ctrl[`SPS_C_FLOW] ? flow_pulse_i : rtc_i.tick;
    // Freeze only counts when reload is off
    hold  = inh & ~storm & ~s_q.ctrl[`SPS_C_RESTART] &
            s_q.ctrl[`SPS_C_FREEZE]; // R14
    fire  = 1'b0;
    adv   = 1'b0;
    msum  = 12'({1'b0, rtc_i.mins} + {4'h0, s_q.dly});
    if (msum >= `SPS_DAY_MIN) begin
      msum = 12'(msum - `SPS_DAY_MIN);
    end
    // Key time match on the minute boundary
    k_stop = 1'b0;
    k_res  = 1'b0;
    for (int i = 0; i < `SPS_NKEY; i++) begin
      if (s_q.kval[i] && (s_q.kmin[i] == rtc_i.mins)) begin
        if (i < `SPS_NSTOP) begin
          k_stop = 1'b1; // R1
        end else begin
          k_res = 1'b1; // R1
        end
      end
    end
    if (!bnd || storm || !s_q.ctrl[`SPS_C_SREN]) begin
      k_stop = 1'b0; // R2
      k_res  = 1'b0; // R2
    end

    // Register writes
    if (wr) begin
      case (paddr_i)
        `SPS_CTRL_OFS: begin
          s_d.ctrl = pwdata_i[15:0];
          s_d.ctrl[`SPS_C_START]  = 1'b0;
          s_d.ctrl[`SPS_C_REINIT] = 1'b0;
          s_d.ctrl[`SPS_C_ABORT]  = 1'b0;
          if (pwdata_i[`SPS_C_REINIT]) begin
            s_d.pre  = `SPS_PRE_RST; // R22
            s_d.ctrl = `SPS_CTRL_RST;
            s_d.dly  = `SPS_DLY_RST;
          end
        end
        `SPS_DLY_OFS: begin
          s_d.dly   = pwdata_i[7:0];
          s_d.stmin = pwdata_i[18:8];
        end
        `SPS_INT_OFS: begin
          s_d.sint  = pwdata_i[15:0];
          s_d.swint = pwdata_i[31:16];
        end
        `SPS_PRG_OFS: begin
          s_d.pre  = clip(pwdata_i[13:0]); // R22
          s_d.post = clip(pwdata_i[29:16]); // R22
        end
        `SPS_KEY_OFS: begin
          if (pwdata_i[4:0] < 5'(`SPS_NKEY)) begin
            s_d.kval[pwdata_i[4:0]] = pwdata_i[5]; // R1
            s_d.kmin[pwdata_i[4:0]] = pwdata_i[18:8];
          end
        end
        default: begin
        end
      endcase
    end

    // Read data is captured in the setup cycle
    if (psel_i && !penable_i) begin
      case (paddr_i)
        `SPS_CTRL_OFS: s_d.rdata = {16'h0000, s_q.ctrl};
        `SPS_DLY_OFS:  s_d.rdata = {13'h0000, s_q.stmin, s_q.dly};
        `SPS_INT_OFS:  s_d.rdata = {s_q.swint, s_q.sint};
        `SPS_PRG_OFS:  s_d.rdata = {2'h0, s_q.post, 2'h0, s_q.pre};
        `SPS_STAT_OFS: s_d.rdata = {16'h0000, s_q.dep, enable_i,
                                    s_q.bot, s_q.st};
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Routine sequencing
    case (s_q.st)
      SPS_IDLE: begin
        if (start) begin
          s_d.swc = s_q.swint;
          // Settings written with the start strobe apply to this start
          if (s_d.ctrl[`SPS_C_HASST]) begin
            s_d.tgt = s_q.stmin; // R8
            s_d.st  = SPS_WAIT;
          end else if (s_q.dly == 8'h00) begin
            s_d.st = SPS_RUN; // R5
            fire   = 1'b1; // R5
            // Time pacing counts from :00 of this minute
            if (s_d.ctrl[`SPS_C_FLOW]) begin
              s_d.cnt = s_q.sint; // R6
            end else if (s_q.sint > {10'h000, rtc_i.sec}) begin
              s_d.cnt = 16'(s_q.sint - {10'h000, rtc_i.sec}); // R6
            end else begin
              s_d.cnt = 16'h0001; // R6
            end
          end else begin
            s_d.tgt = msum[10:0]; // R7
            s_d.st  = SPS_WAIT;
          end
        end
      end
      SPS_WAIT: begin
        if (bnd && (rtc_i.mins == s_q.tgt)) begin
          s_d.st  = SPS_RUN; // R7
          s_d.cnt = s_q.sint; // R7
          s_d.swc = s_q.swint;
          fire    = 1'b1;
        end
      end
      SPS_RUN: begin
        // Countdown; runs on while inhibited unless frozen
        if (pace && !hold) begin
          if (s_q.cnt <= 16'h0001) begin
            s_d.cnt = s_q.sint;
            fire    = ~inh;
          end else begin
            s_d.cnt = 16'(s_q.cnt - 16'h0001); // R14
          end
        end
        // Switches during an inhibit are not counted
        if (s_q.ctrl[`SPS_C_TSW] && rtc_i.tick && !inh) begin
          if (s_q.swc <= 16'h0001) begin
            s_d.swc = s_q.swint;
            adv     = 1'b1;
          end else begin
            s_d.swc = 16'(s_q.swc - 16'h0001);
          end
        end
        if (en_fall && s_q.ctrl[`SPS_C_ONINH]) begin
          fire = 1'b1; // R11
        end
        if (en_rise) begin
          if (s_q.ctrl[`SPS_C_RESTART]) begin
            s_d.cnt = s_q.sint; // R13
          end
          if (s_q.ctrl[`SPS_C_ONENA]) begin
            fire = 1'b1; // R12
          end
          // One set forward, however long the inhibit
          if (s_q.dep != 8'h00) begin
            adv     = 1'b1; // R15
            s_d.swc = s_q.swint; // R16
          end
        end
        if (k_stop) begin
          s_d.st = SPS_STOP;
          fire   = fire | s_q.ctrl[`SPS_C_ATSTOP]; // R4
        end
      end
      SPS_STOP: begin
        if (k_res) begin
          s_d.st  = SPS_RUN;
          s_d.swc = s_q.swint; // R3
          fire    = s_q.ctrl[`SPS_C_ATRES]; // R4
        end
      end
      default: begin
        s_d.st = SPS_IDLE;
      end
    endcase
    if (wr && (paddr_i == `SPS_CTRL_OFS) && pwdata_i[`SPS_C_ABORT]) begin
      s_d.st = SPS_IDLE;
      fire   = 1'b0;
      adv    = 1'b0;
    end

    // Bottle set bookkeeping
    if (adv) begin
      s_d.bot = nxt_bot(s_q.bot); // R16
      s_d.dep = 8'h00;
    end else if (sample_done_i && s_q.dep != 8'hff) begin
      s_d.dep = 8'(s_q.dep + 8'h01);
    end

    // Bottle train: high and low halves of BIT_CYC cycles each
    if (fire) begin
      s_d.samp = 1'b1;
      s_d.bpn  = {s_d.bot, 1'b0}; // R18
      s_d.bitc = BIT_CYC;
    end else if (s_q.bpn != 6'h00) begin
      if (s_q.bitc <= 32'h0000_0001) begin
        s_d.bitc = BIT_CYC;
        s_d.bpn  = 6'(s_q.bpn - 6'h01);
      end else begin
        s_d.bitc = 32'(s_q.bitc - 32'h0000_0001); // R18
      end
    end
    s_d.bph = (s_d.bpn != 6'h00) & ~s_d.bpn[0]; // R23

    // Event mark: trigger edge picks purge or forward start
    trig  = s_q.ctrl[`SPS_C_FWD] ? (pump_i.fwd & ~s_q.fw_q)
                                 : (pump_i.pre & ~s_q.pp_q); // R21
    phase = s_q.ctrl[`SPS_C_FWD] ? pump_i.fwd
                                 : (pump_i.pre | pump_i.fwd | pump_i.post); // R20
    if (trig) begin
      s_d.evc = EVM_CYC; // R19
    end else if (s_q.evc != 32'h0000_0000) begin
      s_d.evc = 32'(s_q.evc - 32'h0000_0001);
    end
    // Level modes stretch to the minimum width
    s_d.evm = (s_d.evc != 32'h0000_0000) |
              (~s_q.ctrl[`SPS_C_PULSE] & phase); // R17
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q       <= '0;
      s_q.st    <= SPS_IDLE;
      s_q.ctrl  <= `SPS_CTRL_RST;
      s_q.dly   <= `SPS_DLY_RST;
      s_q.pre   <= `SPS_PRE_RST;
      s_q.post  <= `SPS_POST_RST;
      s_q.bot   <= 5'h01;
      s_q.sint  <= 16'h0001;
      s_q.swint <= 16'h0001;
      s_q.en_q  <= 1'b1; // Idle level of the pin, no false edge
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero-wait slave: data was latched in the setup cycle
  assign pready_o       = 1'b1;
  assign pslverr_o      = psel_i & penable_i & ~hit(paddr_i);
  assign prdata_o       = s_q.rdata;
  assign sample_req_o   = s_q.samp;
  assign event_mark_o   = s_q.evm;
  assign bottle_pulse_o = s_q.bph;
  assign bottle_num_o   = s_q.bot;
  assign pre_purge_o    = s_q.pre;
  assign post_purge_o   = s_q.post;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence idle_start;
    s_q.st == SPS_IDLE && start && !pwdata_i[`SPS_C_ABORT];
  endsequence

  start_now_a: assert property ( // R5
    idle_start and (!s_d.ctrl[`SPS_C_HASST] && s_q.dly == 8'h00)
    |=> sample_req_o && s_q.st == SPS_RUN)
    else $error("zero delay did not start at once");

  delay_wait_a: assert property ( // R7
    idle_start and (!s_d.ctrl[`SPS_C_HASST] && s_q.dly != 8'h00)
    |=> s_q.st == SPS_WAIT && !sample_req_o && s_q.tgt == $past(msum[10:0]))
    else $error("delayed start not aligned");

  start_time_a: assert property ( // R8
    idle_start and s_d.ctrl[`SPS_C_HASST]
    |=> s_q.st == SPS_WAIT && s_q.tgt == $past(s_q.stmin))
    else $error("start time not used");

  storm_keys_a: assert property ( // R2
    s_q.st == SPS_RUN && storm |=> s_q.st != SPS_STOP)
    else $error("stop taken in burst routine");

  inhibit_samp_a: assert property ( // R11
    s_q.st == SPS_RUN && en_fall && s_q.ctrl[`SPS_C_ONINH]
    && !wr |=> sample_req_o)
    else $error("no sample on inhibit");

  enable_samp_a: assert property ( // R12
    s_q.st == SPS_RUN && en_rise && s_q.ctrl[`SPS_C_ONENA]
    && !wr |=> sample_req_o)
    else $error("no sample on enable");

  reload_int_a: assert property ( // R13
    s_q.st == SPS_RUN && en_rise && s_q.ctrl[`SPS_C_RESTART]
    && !wr |=> s_q.cnt == $past(s_q.sint))
    else $error("interval not reloaded");

  freeze_cnt_a: assert property ( // R14
    s_q.st == SPS_RUN && hold && !wr |=> $stable(s_q.cnt))
    else $error("countdown moved while frozen");

  purge_range_a: assert property ( // R22
    s_q.pre <= `SPS_PURGE_MAX && s_q.post <= `SPS_PURGE_MAX)
    else $error("purge count out of range");

  mark_start_a: assert property ( // R19
    trig |=> s_q.evc == EVM_CYC ##1 event_mark_o)
    else $error("event mark not started");

  bottle_train_a: assert property ( // R18
    sample_req_o |-> s_q.bpn == {s_q.bot, 1'b0} ##1 bottle_pulse_o)
    else $error("bottle train wrong length");

  pulse_quiet_a: assert property ( // R23
    s_q.ctrl[`SPS_C_PULSE] && s_q.evc == 32'h0 && !trig
    && $stable(s_q.ctrl) |=> !event_mark_o)
    else $error("event mark outside interval");
endmodule : sps_sequencer

/* verification/sps_meter.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Flow meter model: drives enable, times the pin outputs
// ----------------------------------------
module sps_meter (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       want_en_i,
  input  wire logic       clear_i,
  input  wire logic       mark_i,
  input  wire logic       bottle_i,
  output logic            enable_o,
  output logic [7:0]      mark_len_o,
  output logic [7:0]      pulse_cnt_o,
  output logic [7:0]      pulse_wid_o
);
  logic [7:0] run_q;
  logic [7:0] wid_q;
  logic       mark_q;
  logic       bot_q;

  // Enable line is always driven: high enables, low inhibits
  always_ff @(posedge core_clk_i) begin
    enable_o <= want_en_i;
  end

  // Length of the last mark, width and count of bottle pulses
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {run_q, wid_q, mark_q, bot_q} <= '0;
      {mark_len_o, pulse_cnt_o, pulse_wid_o} <= '0;
    end else begin
      mark_q <= mark_i;
      bot_q  <= bottle_i;
      run_q  <= mark_i ? run_q + 8'd1 : 8'd0;
      wid_q  <= bottle_i ? wid_q + 8'd1 : 8'd0;
      if (mark_q && !mark_i) mark_len_o <= run_q;
      if (bot_q && !bottle_i) pulse_wid_o <= wid_q;
      if (bottle_i && !bot_q) pulse_cnt_o <= pulse_cnt_o + 8'd1;
      // Clear wins so mark length and pulse count start from zero; pulse width is kept
      if (clear_i) begin
        mark_len_o  <= '0;
        pulse_cnt_o <= '0;
      end
    end
  end
endmodule : sps_meter

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
  import sps_pkg::*;
  localparam int EVM = 20;
  localparam int BIT = 4;
  logic        core_clk_i, reset_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, enable_i, sample_done_i, sample_req_o;
  logic        event_mark_o, bottle_pulse_o, want_en, clear, err;
  logic [4:0]  bottle_num_o;
  logic [13:0] pre_purge_o, post_purge_o;
  logic [7:0]  mlen, pcnt, pwid;
  sps_rtc_t    rtc_i;
  sps_pump_t   pump_i;
  int          bad_count, check_count, req_cnt, rdiv, c0;

  sps_sequencer #(.EVM_CYC(EVM), .BIT_CYC(BIT)) sps_sequencer_inst (
    .core_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rtc_i, .pump_i, .flow_pulse_i(1'b0),
    .enable_i, .sample_done_i, .sample_req_o, .event_mark_o, .bottle_pulse_o,
    .bottle_num_o, .pre_purge_o, .post_purge_o);

  sps_meter sps_meter_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .want_en_i(want_en),
    .clear_i(clear), .mark_i(event_mark_o), .bottle_i(bottle_pulse_o),
    .enable_o(enable_i), .mark_len_o(mlen), .pulse_cnt_o(pcnt), .pulse_wid_o(pwid));

  // ----------------------------------------
  // Clock, time base, pump deposit
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // One second every four cycles keeps minute waits short
  always @(posedge core_clk_i) begin
    rdiv <= (rdiv + 1) % 4;
    rtc_i.tick <= (rdiv == 3);
    if (rdiv == 3) begin
      rtc_i.sec <= (rtc_i.sec == 6'd59) ? 6'd0 : rtc_i.sec + 6'd1;
      if (rtc_i.sec == 6'd59) rtc_i.mins <= rtc_i.mins + 11'd1;
    end
    sample_done_i <= sample_req_o;
    if (sample_req_o === 1'b1) req_cnt <= req_cnt + 1;
  end

  // ----------------------------------------
  // Bus, compare and helper tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  task automatic clr;
    clear <= 1'b1;
    @(posedge core_clk_i);
    clear <= 1'b0;
  endtask : clr

  task automatic pump_run(input int a, input int b, input int c);
    pump_i.pre <= 1'b1;
    cyc(a);
    pump_i.pre <= 1'b0;
    if (b > 0) begin
      pump_i.fwd <= 1'b1;
      cyc(b);
      pump_i.fwd <= 1'b0;
    end
    if (c > 0) begin
      pump_i.post <= 1'b1;
      cyc(c);
      pump_i.post <= 1'b0;
    end
    cyc(EVM + 10);
  endtask : pump_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    check({event_mark_o, bottle_pulse_o}, 0);
    check(pre_purge_o, 14'd150);
    apb(1'b1, 8'h0c, 32'h0000_3fff);
    apb(1'b0, 8'h0c, 0);
    check(rd, 32'd9999);
    check(pre_purge_o, 14'd9999);
    apb(1'b1, 8'h00, 32'h4000);
    apb(1'b0, 8'h0c, 0);
    check(rd[13:0], 14'd150);
    apb(1'b0, 8'h40, 0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_run;
    apb(1'b1, 8'h08, 32'hffff_ffff);
    apb(1'b1, 8'h04, 0);
    clr;
    c0 = req_cnt;
    apb(1'b1, 8'h00, 32'h301);
    cyc(3);
    check(32'(req_cnt - c0), 1);
    cyc(20);
    check({pcnt, pwid}, {8'd1, 8'(BIT)});
    c0 = req_cnt;
    want_en <= 1'b0;
    cyc(8);
    check(32'(req_cnt - c0), 0);
    clr;
    want_en <= 1'b1;
    cyc(8);
    check(32'(req_cnt - c0), 1);
    check(bottle_num_o, 5'd2);
    cyc(30);
    check(pcnt, 8'd2);
    apb(1'b1, 8'h00, 32'h480);
    c0 = req_cnt;
    want_en <= 1'b0;
    cyc(8);
    check(32'(req_cnt - c0), 1);
    want_en <= 1'b1;
    cyc(8);
    check(32'(req_cnt - c0), 1);
    check(bottle_num_o, 5'd3);
    apb(1'b1, 8'h00, 32'h182);
    c0 = req_cnt;
    want_en <= 1'b0;
    cyc(8);
    want_en <= 1'b1;
    cyc(8);
    check(32'(req_cnt - c0), 0);
    apb(1'b1, 8'h00, 32'h8000);
    apb(1'b0, 8'h14, 0);
    check(rd[1:0], 2'b00);
    $display("test run done");
  endtask : t_run

  // Starts at :30 so the target minute cannot slip during the write
  task automatic t_start(input logic [31:0] ctrl, input logic [31:0] dly, input int d,
                         input int pre);
    int tgt;
    int n;
    n = 0;
    while (rtc_i.sec != 6'd30 && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    tgt = rtc_i.mins + d;
    apb(1'b1, 8'h08, {16'h0001, 16'd60});
    apb(1'b1, 8'h04, dly | (32'(tgt) << 8));
    c0 = req_cnt;
    apb(1'b1, 8'h00, ctrl);
    n = 0;
    while (!(rtc_i.tick === 1'b1 && rtc_i.sec == 0 && rtc_i.mins == tgt) && n < 900) begin
      @(posedge core_clk_i);
      n++;
    end
    check(32'(req_cnt - c0), pre);
    cyc(3);
    check(32'(req_cnt - c0), pre + 1);
    apb(1'b1, 8'h00, 32'h8000);
    $display("test start done");
  endtask : t_start

  // Stop key one minute on, resume key two minutes on
  task automatic t_keys;
    int m;
    while (rtc_i.sec != 6'd30) @(posedge core_clk_i);
    m = rtc_i.mins;
    apb(1'b1, 8'h08, 32'hffff_ffff);
    apb(1'b1, 8'h04, 0);
    apb(1'b1, 8'h10, 32'h20 | (32'(m + 1) << 8));
    apb(1'b1, 8'h10, 32'h2c | (32'(m + 2) << 8));
    c0 = req_cnt;
    apb(1'b1, 8'h00, 32'h3d);
    cyc(3);
    check(32'(req_cnt - c0), 1);
    cyc(480);
    apb(1'b0, 8'h14, 0);
    check(rd[1:0], 2'b11);
    check(32'(req_cnt - c0), 3);
    apb(1'b1, 8'h00, 32'h8000);
    $display("test keys done");
  endtask : t_keys

  task automatic t_mark;
    clr;
    apb(1'b1, 8'h00, 32'h1000);
    pump_run(5, 5, 5);
    check(mlen, 8'(EVM));
    clr;
    apb(1'b1, 8'h00, 32'h3000);
    pump_run(5, 0, 0);
    check(mlen, 0);
    pump_run(5, 5, 5);
    check(mlen, 8'(EVM));
    apb(1'b1, 8'h00, 32'h2000);
    pump_run(10, 40, 10);
    check(mlen, 8'd40);
    apb(1'b1, 8'h00, 32'h0);
    pump_run(10, 20, 10);
    check(mlen, 8'd40);
    pump_run(3, 3, 3);
    check(mlen, 8'(EVM));
    $display("test mark done");
  endtask : t_mark

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Whole run needs well under ten thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    stop_test;
  end

  initial begin
    {reset_i, want_en} = 2'b11;
    {psel_i, penable_i, pwrite_i, clear, sample_done_i} = '0;
    {paddr_i, pwdata_i, pump_i} = '0;
    rtc_i = '{tick: 1'b0, sec: 6'd0, mins: 11'd100};
    {rdiv, req_cnt, bad_count, check_count, c0} = '0;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_run;
    t_start(32'h1, 32'h0, 1, 1);
    t_start(32'h1, 32'h1, 1, 0);
    t_start(32'h1, 32'h2, 2, 0);
    t_start(32'h41, 32'h5, 1, 0);
    t_keys;
    t_mark;
    stop_test;
  end
endmodule : tb
